// >>> logic/fcei_top.sv
// fc transmit stimulus injector: alarms, errors, pacing and tx deviation
// assumes an ahb-lite master, and a word stream with per-word markers
`timescale 1ns/10ps
`include "fcei_consts.svh"
module fcei_top
  import fcei_pkg::*;
#(
  parameter int unsigned SEC_CYC   = `FCEI_SEC_CYC,
  parameter int unsigned RATIO_MIN = `FCEI_RATIO_MIN
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] tx_in_data,     // word from the frame builder
  input  wire logic [3:0]  tx_in_k,        // control-character flags per byte
  input  wire logic        tx_in_idle,     // word is idle fill between frames
  input  wire logic        tx_in_payload,  // word lies in frame content
  input  wire logic        tx_in_crc,      // word is the frame crc
  output logic      [31:0] tx_out_data,
  output logic      [3:0]  tx_out_k,
  output logic             tx_out_symerr,  // encoder sends a bad code group
  output logic             tx_out_blkerr,  // 64b/66b coder corrupts this block
  output logic      [15:0] tx_freq_dev,    // signed line frequency offset
  output logic             ins_active      // insert indicator
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [2:0]  alarm_q;    // selected alarm
  logic [2:0]  err_q;      // selected error type
  logic [3:0]  mode_q;     // insertion mode
  logic        hirate_q;   // port runs fc1200 or fc1600
  logic        she_q;      // sof header eof framing
  logic [15:0] burst_q;    // errors per event
  logic [15:0] dev_q;      // deviation, two's complement
  logic [15:0] errcnt_q;   // errors inserted since reset
  logic [31:0] hrdata_q;
  logic [7:0]  addr_q;     // data-phase offset
  logic        wr_q;       // data phase of a write
  logic        ap;         // address phase taken
  logic [31:0] rd_mux;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // ----------------------------------------------------------------
  // insertion state
  // ----------------------------------------------------------------
  logic [15:0]    left_q;    // errors still owed by the current burst
  logic [3:0]     ten_q;     // seconds into the ten-second period
  fcei_alarm_st_e ast_q;     // alarm sender state
  fcei_alarm_st_e ast_d;
  logic           err_ok;    // selected type allowed in this setup
  logic           ratio_md;  // a ratio mode is selected
  logic           trig;      // a burst starts this word
  logic           drop;      // partial burst discarded
  logic           opp;       // this word can carry the selected error
  logic           consume;   // this word carries one error
  logic           man_wr;    // software insert trigger
  logic           cfg_chg;   // error type or mode rewritten
  logic [2:0]     rom_sel;
  logic [31:0]    os_word;

  fcei_pace_if pif ();

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states, always okay
  // ----------------------------------------------------------------
  assign ap        = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // control word as read back
  assign ctrl_rd = {14'h0, she_q, hirate_q, 4'h0, mode_q, 1'b0, err_q, 1'b0, alarm_q};
  assign stat_rd = {29'h0, err_ok, ast_q == FCEI_AS_SEND, ins_active};

  // address phase capture; hsize ignored since only words are mapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h0;
    end else begin
      wr_q <= ap && hwrite;
      if (ap) addr_q <= haddr[7:0];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (haddr[7:0])
      `FCEI_OFS_CTRL:   rd_mux = ctrl_rd;
      `FCEI_OFS_BURST:  rd_mux = {16'h0, burst_q};
      `FCEI_OFS_DEV:    rd_mux = {16'h0, dev_q};
      `FCEI_OFS_STATUS: rd_mux = stat_rd;
      `FCEI_OFS_ERRCNT: rd_mux = {16'h0, errcnt_q};
      default:          rd_mux = 32'h0;
    endcase
  end

  // read data registered at the address phase, stands through data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_q <= 32'h0;
    else if (ap && !hwrite) hrdata_q <= rd_mux;
  end

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q  <= 3'h0;
      err_q    <= 3'h0;
      mode_q   <= 4'h0;
      hirate_q <= 1'b0;
      she_q    <= 1'b0;
      burst_q  <= `FCEI_RST_BURST;
      dev_q    <= `FCEI_RST_DEV;
    end else if (wr_q) begin
      case (addr_q)
        `FCEI_OFS_CTRL: begin
          alarm_q  <= hwdata[`FCEI_CTRL_ALARM_LSB +: 3];
          err_q    <= hwdata[`FCEI_CTRL_ERR_LSB +: 3];
          mode_q   <= hwdata[`FCEI_CTRL_MODE_LSB +: 4];
          hirate_q <= hwdata[`FCEI_CTRL_HIRATE_BIT];
          she_q    <= hwdata[`FCEI_CTRL_SHE_BIT];
        end
        `FCEI_OFS_BURST: burst_q <= hwdata[15:0];
        `FCEI_OFS_DEV:   dev_q   <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // deviation goes straight to the clock synthesiser; sign sets direction
  assign tx_freq_dev = dev_q;

  // ----------------------------------------------------------------
  // type availability and event decode
  // ----------------------------------------------------------------
  // types that the port setup hides behave as none
  always_comb begin
    case (fcei_err_e'(err_q))
      FCEI_ER_BIT:  err_ok = 1'b1;
      FCEI_ER_SYM:  err_ok = !hirate_q;
      FCEI_ER_RRDY: err_ok = 1'b1;
      FCEI_ER_CRC:  err_ok = !she_q;
      FCEI_ER_BLK:  err_ok = hirate_q;
      default:      err_ok = 1'b0;
    endcase
  end

  assign ratio_md = mode_q >= FCEI_MD_R2 && mode_q <= FCEI_MD_R7;
  assign man_wr   = wr_q && addr_q == `FCEI_OFS_INSERT && hwdata[0];
  assign cfg_chg  = wr_q && addr_q == `FCEI_OFS_CTRL &&
                    (hwdata[`FCEI_CTRL_ERR_LSB +: 3] != err_q ||
                     hwdata[`FCEI_CTRL_MODE_LSB +: 4] != mode_q);

  // pacer realigns whenever the error type or mode changes
  assign pif.restart   = cfg_chg;
  assign pif.ratio_en  = ratio_md;
  assign pif.ratio_sel = 3'(mode_q - FCEI_MD_R2);

  fcei_pacer #(
    .SEC_CYC   (SEC_CYC),
    .RATIO_MIN (RATIO_MIN)
  ) u_pacer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pif     (pif)
  );

  // ten-second period counted in second ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ten_q <= 4'h0;
    else if (cfg_chg) ten_q <= 4'h0;
    else if (pif.sec_tick) ten_q <= (ten_q == `FCEI_TEN_LAST) ? 4'h0 : ten_q + 4'h1;
  end

  // burst start per mode; a manual write in ratio mode falls through
  always_comb begin
    case (fcei_mode_e'(mode_q))
      FCEI_MD_MAN: trig = man_wr;
      FCEI_MD_SEC: trig = pif.sec_tick;
      FCEI_MD_TEN: trig = pif.sec_tick && ten_q == `FCEI_TEN_LAST;
      default:     trig = ratio_md && pif.ratio_hit;
    endcase
  end

  // mode off and any change of type or mode discard what is owed
  assign drop = cfg_chg || mode_q == FCEI_MD_OFF || !err_ok;

  // ----------------------------------------------------------------
  // alarm sender
  // ----------------------------------------------------------------
  // entry waits for an idle word so no frame is cut mid-way
  always_comb begin
    case (ast_q)
      FCEI_AS_IDLE: ast_d = (alarm_q != FCEI_AL_NONE && tx_in_idle) ?
                            FCEI_AS_SEND : FCEI_AS_IDLE;
      FCEI_AS_SEND: ast_d = (alarm_q == FCEI_AL_NONE) ? FCEI_AS_IDLE : FCEI_AS_SEND;
      default:      ast_d = FCEI_AS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ast_q <= FCEI_AS_IDLE;
    else ast_q <= ast_d;
  end

  // ----------------------------------------------------------------
  // error placement
  // ----------------------------------------------------------------
  // which words can carry the selected error
  always_comb begin
    case (fcei_err_e'(err_q))
      FCEI_ER_BIT:  opp = tx_in_payload;
      FCEI_ER_RRDY: opp = tx_in_idle;
      FCEI_ER_CRC:  opp = tx_in_crc;
      FCEI_ER_SYM:  opp = 1'b1;
      FCEI_ER_BLK:  opp = 1'b1;
      default:      opp = 1'b0;
    endcase
  end

  // the alarm owns the line; errors wait while it is sent
  assign consume = left_q != 16'h0 && opp && !drop && ast_d == FCEI_AS_IDLE;

  // burst bookkeeping; a fresh start reloads the full length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) left_q <= 16'h0;
    else if (drop) left_q <= 16'h0;
    else if (trig) left_q <= burst_q;
    else if (consume) left_q <= left_q - 16'h1;
  end

  // running count of inserted errors, wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) errcnt_q <= 16'h0;
    else if (consume) errcnt_q <= errcnt_q + 16'h1;
  end

  assign rom_sel = (ast_d == FCEI_AS_SEND) ? alarm_q : 3'(FCEI_OS_RRDY);

  fcei_os_rom u_rom (
    .sel     (rom_sel),
    .os_word (os_word)
  );

  // ----------------------------------------------------------------
  // output word, one word of latency
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_out_data   <= 32'h0;
      tx_out_k      <= 4'h0;
      tx_out_symerr <= 1'b0;
      tx_out_blkerr <= 1'b0;
    end else begin
      tx_out_data   <= tx_in_data;
      tx_out_k      <= tx_in_k;
      tx_out_symerr <= 1'b0;
      tx_out_blkerr <= 1'b0;
      if (ast_d == FCEI_AS_SEND) begin
        // every word replaced while the alarm lasts
        tx_out_data <= os_word;
        tx_out_k    <= 4'h8;
      end else if (consume) begin
        case (fcei_err_e'(err_q))
          FCEI_ER_BIT:  tx_out_data <= tx_in_data ^ 32'h1;
          FCEI_ER_CRC:  tx_out_data <= tx_in_data ^ 32'h1;
          FCEI_ER_SYM:  tx_out_symerr <= 1'b1;
          FCEI_ER_BLK:  tx_out_blkerr <= 1'b1;
          FCEI_ER_RRDY: begin
            tx_out_data <= os_word;
            tx_out_k    <= 4'h8;
          end
          default: ;
        endcase
      end
    end
  end

  // indicator: owed errors, or simply armed in the ratio modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ins_active <= 1'b0;
    else if (ratio_md) ins_active <= err_ok;
    else ins_active <= left_q != 16'h0 && !drop;
  end
endmodule

// >>> logic/fcei_consts.svh
// constants of the fc error and alarm injector: offsets, fields, resets, codes
// assumes inclusion by bare name from the design files and the package user
`ifndef FCEI_CONSTS_SVH
`define FCEI_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCEI_OFS_CTRL    8'h00
`define FCEI_OFS_BURST   8'h04
`define FCEI_OFS_DEV     8'h08
`define FCEI_OFS_INSERT  8'h0c
`define FCEI_OFS_STATUS  8'h10
`define FCEI_OFS_ERRCNT  8'h14
// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define FCEI_CTRL_ALARM_LSB  0
`define FCEI_CTRL_ERR_LSB    4
`define FCEI_CTRL_MODE_LSB   8
`define FCEI_CTRL_HIRATE_BIT 16
`define FCEI_CTRL_SHE_BIT    17
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FCEI_RST_BURST 16'h0001
`define FCEI_RST_DEV   16'h0000
// ----------------------------------------------------------------
// transmission characters, code is {y, x} of Dx.y
// ----------------------------------------------------------------
`define FCEI_K28_5 8'hbc
`define FCEI_D9_2  8'h49
`define FCEI_D31_5 8'hbf
`define FCEI_D21_1 8'h35
`define FCEI_D21_2 8'h55
`define FCEI_D5_2  8'h45
`define FCEI_D10_4 8'h8a
`define FCEI_D21_4 8'h95
`define FCEI_D10_2 8'h4a
// ----------------------------------------------------------------
// timing: one second at the 25 ns word clock, first ratio period
// ----------------------------------------------------------------
`define FCEI_SEC_NS    1000000000
`define FCEI_CLK_NS    25
`define FCEI_SEC_CYC   (`FCEI_SEC_NS / `FCEI_CLK_NS)
`define FCEI_RATIO_MIN 100
`define FCEI_TEN_LAST  4'h9
`endif

// >>> logic/fcei_pkg.sv
// types of the fc error and alarm injector
// assumes nothing beyond a systemverilog compiler
package fcei_pkg;
  typedef enum logic [2:0] {
    FCEI_AL_NONE = 3'b000, FCEI_AL_LR = 3'b001, FCEI_AL_LRR = 3'b010,
    FCEI_AL_NOS = 3'b011, FCEI_AL_OLS = 3'b100, FCEI_OS_RRDY = 3'b101
  } fcei_os_e;
  typedef enum logic [2:0] {
    FCEI_ER_NONE = 3'b000, FCEI_ER_BIT = 3'b001, FCEI_ER_SYM = 3'b010,
    FCEI_ER_RRDY = 3'b011, FCEI_ER_CRC = 3'b100, FCEI_ER_BLK = 3'b101
  } fcei_err_e;
  typedef enum logic [3:0] {
    FCEI_MD_OFF = 4'h0, FCEI_MD_MAN = 4'h1, FCEI_MD_SEC = 4'h2, FCEI_MD_TEN = 4'h3,
    FCEI_MD_R2 = 4'h4, FCEI_MD_R7 = 4'h9
  } fcei_mode_e;
  typedef enum logic [0:0] {
    FCEI_AS_IDLE = 1'b0, FCEI_AS_SEND = 1'b1
  } fcei_alarm_st_e;
endpackage

// >>> logic/fcei_pace_if.sv
// carrier between the injector core and its burst pacer
// assumes both ends sit on the same word clock
`timescale 1ns/10ps
interface fcei_pace_if;
  logic       restart;    // realign periods after a mode change
  logic       ratio_en;   // a ratio mode is selected
  logic [2:0] ratio_sel;  // 0 = 1e-02 .. 5 = 1e-07
  logic       sec_tick;   // one word per elapsed second
  logic       ratio_hit;  // one word per elapsed ratio period
  modport pacer (input restart, ratio_en, ratio_sel, output sec_tick, ratio_hit);
  modport user  (output restart, ratio_en, ratio_sel, input sec_tick, ratio_hit);
endinterface

// >>> logic/fcei_pacer.sv
// burst pacer: second ticks and ratio-period hits counted in transmit words
// assumes one transmission word per clock
`timescale 1ns/10ps
`include "fcei_consts.svh"
module fcei_pacer #(
  parameter int unsigned SEC_CYC   = `FCEI_SEC_CYC,
  parameter int unsigned RATIO_MIN = `FCEI_RATIO_MIN
) (
  input wire logic  hclk,
  input wire logic  hresetn,
  fcei_pace_if.pacer pif
);
  logic [31:0] sec_q;    // cycles into the current second
  logic [31:0] rat_q;    // words into the current ratio period
  logic [31:0] period;   // ratio period in words

  // period is the base times ten per decade step
  always_comb begin
    period = RATIO_MIN;
    for (int i = 0; i < 5; i++) begin
      if (i < int'(pif.ratio_sel)) period = period * 32'd10;
    end
  end

  // second counter, free running except on restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sec_q <= 32'h0;
    else if (pif.restart || sec_q == SEC_CYC - 1) sec_q <= 32'h0;
    else sec_q <= sec_q + 32'h1;
  end

  // ratio counter, idle outside the ratio modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rat_q <= 32'h0;
    else if (pif.restart || !pif.ratio_en || rat_q >= period - 1) rat_q <= 32'h0;
    else rat_q <= rat_q + 32'h1;
  end

  assign pif.sec_tick  = !pif.restart && (sec_q == SEC_CYC - 1);
  assign pif.ratio_hit = pif.ratio_en && !pif.restart && (rat_q >= period - 1);
endmodule

// >>> logic/fcei_os_rom.sv
// ordered-set table: four characters, comma first in the top byte
// assumes the caller flags the top byte as a control character
`timescale 1ns/10ps
`include "fcei_consts.svh"
module fcei_os_rom
  import fcei_pkg::*;
(
  input  wire logic [2:0]  sel,      // fcei_os_e code
  output logic      [31:0] os_word   // character 0 in bits 31:24
);
  // plain lookup; none yields zero
  always_comb begin
    case (fcei_os_e'(sel))
      FCEI_AL_LR:   os_word = {`FCEI_K28_5, `FCEI_D9_2, `FCEI_D31_5, `FCEI_D9_2};
      FCEI_AL_LRR:  os_word = {`FCEI_K28_5, `FCEI_D21_1, `FCEI_D31_5, `FCEI_D9_2};
      FCEI_AL_NOS:  os_word = {`FCEI_K28_5, `FCEI_D21_2, `FCEI_D31_5, `FCEI_D5_2};
      FCEI_AL_OLS:  os_word = {`FCEI_K28_5, `FCEI_D21_1, `FCEI_D10_4, `FCEI_D21_2};
      FCEI_OS_RRDY: os_word = {`FCEI_K28_5, `FCEI_D21_4, `FCEI_D10_2, `FCEI_D10_2};
      default:      os_word = 32'h0;
    endcase
  end
endmodule

// >>> tb/fcei_sva.sv
// checker for the injector top: bus answer, word stream, deviation
// assumes it is bound into fcei_top and sees only that module's ports
`timescale 1ns/10ps
`include "fcei_consts.svh"
module fcei_sva #(
  parameter int unsigned SEC_CYC   = 200,
  parameter int unsigned RATIO_MIN = 10
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic [31:0] tx_in_data,
  input wire logic [3:0]  tx_in_k,
  input wire logic        tx_in_idle,
  input wire logic        tx_in_payload,
  input wire logic        tx_in_crc,
  input wire logic [31:0] tx_out_data,
  input wire logic [3:0]  tx_out_k,
  input wire logic        tx_out_symerr,
  input wire logic        tx_out_blkerr,
  input wire logic [15:0] tx_freq_dev
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  logic [31:0] in_q;    // word taken last edge, the one now at the output
  logic        os_new;  // output carries an ordered set the source never sent
  logic        taken;   // bus address phase accepted
  // no reset; properties read it a cycle after release
  always_ff @(posedge hclk) begin
    in_q <= tx_in_data;
  end
  assign os_new = (tx_out_k == 4'h8) && (tx_out_data != in_q);
  assign taken  = hsel && hready && htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("bus slave stalled");
  property p_rd0; (taken && !hwrite && haddr[7:0] == `FCEI_OFS_INSERT) |=> hrdata == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("trigger place read not zero");
  property p_comma; (tx_out_k == 4'h8 && $past(tx_in_k) != 4'h8)
    |-> tx_out_data[31:24] == `FCEI_K28_5; endproperty
  a_comma: assert property (p_comma) else $error("ordered set without comma");
  property p_start; $rose(os_new) |-> $past(tx_in_idle); endproperty
  a_start: assert property (p_start) else $error("ordered set not on idle");
  property p_bit; ($past(tx_in_payload) && tx_out_k != 4'h8)
    |-> (tx_out_data ^ in_q) inside {32'h0, 32'h1}; endproperty
  a_bit: assert property (p_bit) else $error("payload word over-corrupted");
  property p_pass; ($past(hresetn) && !$past(tx_in_payload) && !$past(tx_in_crc)
    && tx_out_k != 4'h8) |-> tx_out_data == in_q; endproperty
  a_pass: assert property (p_pass) else $error("non frame word altered");
  property p_one; !(tx_out_symerr && tx_out_blkerr); endproperty
  a_one: assert property (p_one) else $error("symbol and block error together");
  property p_dev;
    logic [15:0] v;
    (taken && hwrite && haddr[7:0] == `FCEI_OFS_DEV) ##1 (1'b1, v = hwdata[15:0])
      |-> ##[0:2] tx_freq_dev == v;
  endproperty
  a_dev: assert property (p_dev) else $error("deviation not applied");
endmodule
bind fcei_top fcei_sva #(.SEC_CYC(SEC_CYC), .RATIO_MIN(RATIO_MIN)) fcei_sva_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .tx_in_data, .tx_in_k, .tx_in_idle, .tx_in_payload, .tx_in_crc,
  .tx_out_data, .tx_out_k, .tx_out_symerr, .tx_out_blkerr, .tx_freq_dev);

// >>> tb/fcei_link_rx.sv
// far-side link model: takes the per-word error markers and tallies faults
// assumes one word per hclk and the design's per-word error markers
`timescale 1ns/10ps
module fcei_link_rx (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        rx_symerr,
  input wire logic        rx_blkerr,
  output int              sym_cnt,
  output int              blk_cnt
);
  // undecodable groups and bad blocks as the receiver would count them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sym_cnt <= 0;
      blk_cnt <= 0;
    end else begin
      sym_cnt <= sym_cnt + int'(rx_symerr);
      blk_cnt <= blk_cnt + int'(rx_blkerr);
    end
  end
endmodule

// >>> tb/tb_top.sv
// top bench: bus tasks, random word source, reference model of the stream
// assumes design, link model and checker are compiled before it
`timescale 1ns/10ps
`include "fcei_consts.svh"
module tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, tx_in_data = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  tx_in_k = 4'h0;
  logic        tx_in_idle = 1'b0, tx_in_payload = 1'b0, tx_in_crc = 1'b0;
  wire  [31:0] hrdata, tx_out_data;
  wire  [3:0]  tx_out_k;
  wire  [15:0] tx_freq_dev;
  wire         hreadyout, hresp, tx_out_symerr, tx_out_blkerr, ins_active;
  int          sym_cnt, blk_cnt, r;  // link tallies, random word
  int err_total = 0, total_checks = 0, seed = 910, ign = 8, mix = 1, pend = 0, flips = 0;
  int m_al = 0, m_err = 0, m_md = 0, okay = 0;  // model's copy of the settings
  logic        have = 1'b0, skip_q = 1'b1, free = 1'b0, al_on = 1'b0;
  logic [35:0] exp_w;                           // expected {k, word}
  always #12.5 hclk = ~hclk;
  fcei_top #(.SEC_CYC(200), .RATIO_MIN(10)) fcei_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_in_data, .tx_in_k,
    .tx_in_idle, .tx_in_payload, .tx_in_crc, .tx_out_data, .tx_out_k,
    .tx_out_symerr, .tx_out_blkerr, .tx_freq_dev, .ins_active);
  fcei_link_rx fcei_link_rx_inst (.hclk, .hresetn, .rx_symerr(tx_out_symerr),
    .rx_blkerr(tx_out_blkerr), .sym_cnt, .blk_cnt);
  // ----------------------------------------------------------------
  // compare, bus and settings tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    chk_word({4'h0, got}, {4'h0, exp});
  endtask
  // one single transfer; every wait ends only on hready or the watchdog
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    ign = 8;  // source sends neutral words while settings move
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk_val(q & m | {hresp, 31'h0}, e);
  endtask
  // model moves once the write lands
  task automatic cfg(input int al, input int er, input int md, input int hr, input int sh);
    wr(`FCEI_OFS_CTRL, 32'((sh << 17) | (hr << 16) | (md << 8) | (er << 4) | al));
    if (er != m_err || md != m_md) pend = 0;
    m_al = al;
    m_err = er;
    m_md = md;
    okay = int'(er == 1 || er == 3 || (er == 2 && hr == 0) || (er == 4 && sh == 0)
           || (er == 5 && hr == 1));
  endtask
  task automatic trig(input int b);
    wr(`FCEI_OFS_INSERT, 32'h1);
    if (m_md == 1 && okay == 1 && m_err inside {1, 3, 4}) pend = b;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [31:0] os(input int s);
    case (s)
      1: return {`FCEI_K28_5, `FCEI_D9_2, `FCEI_D31_5, `FCEI_D9_2};
      2: return {`FCEI_K28_5, `FCEI_D21_1, `FCEI_D31_5, `FCEI_D9_2};
      3: return {`FCEI_K28_5, `FCEI_D21_2, `FCEI_D31_5, `FCEI_D5_2};
      4: return {`FCEI_K28_5, `FCEI_D21_1, `FCEI_D10_4, `FCEI_D21_2};
      default: return {`FCEI_K28_5, `FCEI_D21_4, `FCEI_D10_2, `FCEI_D10_2};
    endcase
  endfunction
  // word source: class 0 idle, 1 payload, 2 crc, 3 neutral frame word
  always @(posedge hclk) begin
    r = $random(seed);
    r[31:30] = (ign > 0 || mix == 0) ? 2'h3 : (mix == 2) ? 2'h1 : r[31:30];
    tx_in_data <= (r[31:30] == 2'h0) ? {`FCEI_K28_5, r[23:0]} : 32'(r);
    tx_in_k <= (r[31:30] == 2'h0) ? 4'h8 : 4'h0;
    tx_in_idle <= r[31:30] == 2'h0;
    tx_in_payload <= r[31:30] == 2'h1;
    tx_in_crc <= r[31:30] == 2'h2;
  end
  // reference model: one expected word per word taken, checked next edge
  always @(posedge hclk) if (hresetn) begin
    if (have && free) flips += int'((tx_out_data ^ exp_w[31:0]) == 32'h1);
    else if (have && !skip_q) chk_word({tx_out_k, tx_out_data}, exp_w);
    skip_q = ign > 0;
    if (ign > 0) ign--;
    exp_w = {tx_in_k, tx_in_data};
    if (m_al != 0 && (al_on || tx_in_idle)) begin  // alarm enters on idle, then holds
      al_on = 1'b1;
      exp_w = {4'h8, os(m_al)};
    end else begin
      al_on = 1'b0;
      if (pend > 0 && ((m_err == 1 && tx_in_payload) || (m_err == 4 && tx_in_crc))) begin
        exp_w[0] = ~exp_w[0];
        pend--;
      end else if (pend > 0 && m_err == 3 && tx_in_idle) begin
        exp_w = {4'h8, os(5)};
        pend--;
      end
    end
    have = 1'b1;
  end
  // ----------------------------------------------------------------
  // test sequence, watchdog and verdict
  // ----------------------------------------------------------------
  int cs [9] = '{'h1100, 'h2100, 'h3100, 'h4100, 'h5110, 'h2110, 'h4101, 'h5100, 'h1000};
  initial begin
    int b, s0, k0, e;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`FCEI_OFS_BURST, 32'hffff, 32'h1);
    rdc(`FCEI_OFS_DEV, 32'hffff, 32'h0);
    rdc(`FCEI_OFS_INSERT, 32'hffffffff, 32'h0);
    rdc(8'h1c, 32'hffffffff, 32'h0);
    wr(`FCEI_OFS_DEV, 32'h0123);
    run(3);
    chk_val({16'h0, tx_freq_dev}, 32'h0123);
    wr(`FCEI_OFS_DEV, 32'hfe00);
    run(3);
    chk_val({16'h0, tx_freq_dev}, 32'hfe00);
    $display("test registers done");
    for (int a = 1; a <= 4; a++) begin
      cfg(a, 0, 0, 0, 0);
      run(30);
    end
    cfg(0, 0, 0, 0, 0);
    run(20);
    $display("test alarms done");
    foreach (cs[i]) begin
      e = cs[i] >> 12;
      b = 1 + ($unsigned($random(seed)) % 4);
      wr(`FCEI_OFS_BURST, 32'(b));
      cfg(0, e, (cs[i] >> 8) & 15, (cs[i] >> 4) & 15, cs[i] & 15);
      rdc(`FCEI_OFS_STATUS, 32'h4, 32'(okay << 2));
      s0 = sym_cnt;
      k0 = blk_cnt;
      trig(b);
      run(80);
      chk_val(32'(sym_cnt - s0), (e == 2 && okay == 1 && m_md == 1) ? 32'(b) : 32'h0);
      chk_val(32'(blk_cnt - k0), (e == 5 && okay == 1 && m_md == 1) ? 32'(b) : 32'h0);
    end
    $display("test error types done");
    wr(`FCEI_OFS_BURST, 32'h4);
    cfg(0, 1, 1, 0, 0);
    mix = 0;
    trig(4);
    cfg(0, 4, 1, 0, 0);
    cfg(0, 1, 1, 0, 0);
    mix = 1;
    run(60);
    $display("test burst drop done");
    free = 1'b1;
    mix = 2;
    wr(`FCEI_OFS_BURST, 32'h2);
    for (int m = 4; m <= 9; m++) begin
      cfg(0, 1, m, 0, 0);
      flips = 0;
      if (m == 7) trig(2);
      run(m <= 6 ? 25 * (10 ** (m - 4)) : 1000);
      chk_val(32'(flips), m <= 6 ? 32'h4 : 32'h0);
      chk_val({31'h0, ins_active}, 32'h1);
    end
    cfg(0, 1, 2, 0, 0);
    flips = 0;
    run(500);
    chk_val(32'(flips), 32'h4);
    cfg(0, 1, 3, 0, 0);
    flips = 0;
    run(4500);
    chk_val(32'(flips), 32'h4);
    $display("test pacing done");
    results();
  end
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    $display("watchdog expired at %0t", $time);
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
